// ===== design/ivam_map.svh
// Purpose: constants for the interrupt vector address map
// Assumes: word addresses into program flash
// Notes: vectors two words apart, one jump per slot
`ifndef IVAM_MAP_SVH
`define IVAM_MAP_SVH
`define IVAM_ADDR_W 13
`define IVAM_NUM_IRQ 25
`define IVAM_RESET_ADDR 13'h0000
`define IVAM_BOOT_START 13'h0c00
`define IVAM_FUSE_PROGRAMMED 1'h0
`define IVAM_SLOT_WORDS 2
`endif

// ===== design/ivam_pkg.sv
// Purpose: types for the interrupt vector address map
// Assumes: ivam_map.svh holds the numbers
// Notes: irq index 0 is vector number 2
`include "ivam_map.svh"
package ivam_pkg;
  typedef logic [`IVAM_ADDR_W-1:0] ivam_addr_t;
  typedef struct packed {
    logic valid;
    logic isReset;
    logic [4:0] index;
    ivam_addr_t addr;
  } ivam_vec_t;
  typedef enum logic [1:0] {
    IVAM_ST_BOOT = 2'b00,
    IVAM_ST_RUN = 2'b01
  } ivam_state_t;
endpackage

// ===== design/ivam_prio.sv
// Purpose: fixed-priority pick of the lowest pending request
// Assumes: request bit 0 is the highest priority
// Notes: combinational, registered by the caller
`timescale 1ns/100ps
module ivam_prio #(
  parameter int N = 25
) (
  input wire logic [N-1:0] req,
  output logic any,
  output logic [4:0] idx
);
  always_comb begin
    any = 1'b0;
    idx = 5'h00;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = 5'(i);
      end
    end
  end
endmodule // ivam_prio

// ===== design/ivam_vector_map.sv
// Purpose: vector address generation for reset and interrupts
// Assumes: core pulses a request and takes the address one cycle later
// Notes: fuse and select bit are levels from the same clock domain
`timescale 1ns/100ps
`include "ivam_map.svh"

// Contract
// RQ1 - reset starts at 0x0000 unless relocated
// RQ2 - external requests to 0x0002 and 0x0004
// RQ3 - pin change and watchdog to 0x0006-0x000C
// RQ4 - timer two events to 0x000E-0x0012
// RQ5 - timer one events to 0x0014-0x001A
// RQ6 - timer zero events to 0x001C-0x0020
// RQ7 - serial peripheral done to 0x0022
// RQ8 - serial port events to 0x0024-0x0028
// RQ9 - remaining five sources to 0x002A-0x0032
// RQ10 - programmed fuse starts reset at 0x0C00
// RQ11 - fuse plus select moves vectors too
// RQ12 - software sets select before enabling interrupts
// RQ13 - select adds boot start to vectors
// RQ14 - fuse one unprogrammed, zero programmed
// RQ15 - lowest vector number wins
// RQ16 - address is base plus twice (index plus one)
module ivam_vector_map import ivam_pkg::*; #(
  parameter int NUM_IRQ = `IVAM_NUM_IRQ
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic boot_reset_fuse,
  input wire logic vector_select_bit,
  input wire logic [NUM_IRQ-1:0] irqPending,
  input wire logic irqAck,
  output ivam_vec_t vecOut
);
  // ----------------------------------------
  // priority pick
  // ----------------------------------------
  logic anyReq;
  logic [4:0] pickIdx;

  ivam_prio #(.N(NUM_IRQ)) ivam_prio_i (
    .req(irqPending),
    .any(anyReq),
    .idx(pickIdx)
  ); // [RQ15]

  // ----------------------------------------
  // address formation
  // ----------------------------------------
  ivam_state_t state_q, state_d;
  ivam_vec_t vec_q, vec_d;
  ivam_addr_t resetAddr;
  ivam_addr_t vecBase;
  ivam_addr_t slotOff;

  always_comb begin
    // programmed fuse reads as zero
    resetAddr = (boot_reset_fuse == `IVAM_FUSE_PROGRAMMED) ?
      `IVAM_BOOT_START : `IVAM_RESET_ADDR; // [RQ1] [RQ10] [RQ14]
    // select bit alone moves only the vectors, not reset
    vecBase = vector_select_bit ? `IVAM_BOOT_START : `IVAM_RESET_ADDR; // [RQ11] [RQ13]
    // index 0 is vector 2, so slot is index plus one
    slotOff = `IVAM_ADDR_W'((32'(pickIdx) + 1) * `IVAM_SLOT_WORDS); // [RQ16]
  end

  always_comb begin
    state_d = state_q;
    vec_d = vec_q;
    vec_d.valid = 1'b0;
    case (state_q)
      IVAM_ST_BOOT: begin
        vec_d.valid = 1'b1;
        vec_d.isReset = 1'b1;
        vec_d.index = 5'h00;
        vec_d.addr = resetAddr; // [RQ1] [RQ10]
        state_d = IVAM_ST_RUN;
      end
      IVAM_ST_RUN: begin
        // relocation while enabled is the software's hazard
        if (irqAck && anyReq) begin // [RQ12]
          vec_d.valid = 1'b1;
          vec_d.isReset = 1'b0;
          vec_d.index = pickIdx;
          vec_d.addr = vecBase + slotOff; // [RQ2] [RQ3] [RQ4] [RQ5] [RQ6] [RQ7] [RQ8] [RQ9]
        end
      end
      default: state_d = IVAM_ST_BOOT;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= IVAM_ST_BOOT;
      vec_q <= '0;
    end else begin
      state_q <= state_d;
      vec_q <= vec_d;
    end
  end

  assign vecOut = vec_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // a take on the low table or on the boot side, as sampled at the edge
  logic lowTake;
  logic highTake;

  assign lowTake = (state_q == IVAM_ST_RUN) && irqAck && !vector_select_bit;
  assign highTake = (state_q == IVAM_ST_RUN) && irqAck && vector_select_bit;

  a_reset_low: assert property (@(posedge clock) rst |=> (vecOut == '0)) // [RQ1]
    else $error("output not cleared by reset");
  a_reset_addr: assert property (@(posedge clock) // [RQ1]
    ($past(rst) && !rst && boot_reset_fuse) |=> (vecOut.valid && vecOut.addr == 13'h0000))
    else $error("reset vector not at zero");
  a_sel_reset: assert property (@(posedge clock) // [RQ1]
    ($past(rst) && !rst && boot_reset_fuse && vector_select_bit) |=>
    (vecOut.isReset && vecOut.addr == 13'h0000)) else $error("select moved reset vector");
  a_boot_reset: assert property (@(posedge clock) // [RQ10] [RQ14]
    ($past(rst) && !rst && !boot_reset_fuse) |=> (vecOut.isReset && vecOut.addr == 13'h0c00))
    else $error("boot reset vector wrong");
  a_boot_once: assert property (@(posedge clock) disable iff (rst) // [RQ1]
    (state_q == IVAM_ST_BOOT) |=> (state_q == IVAM_ST_RUN && vecOut.valid && vecOut.isReset))
    else $error("boot cycle not a single reset fetch");
  a_fields_hold: assert property (@(posedge clock) disable iff (rst) // [RQ16]
    (!vecOut.valid && !$past(rst)) |-> ($stable(vecOut.addr) && $stable(vecOut.index)))
    else $error("vector fields moved without a take");
  a_ext_zero: assert property (@(posedge clock) disable iff (rst) // [RQ2]
    (lowTake && irqPending[0]) |=> (vecOut.valid && vecOut.addr == 13'h0002))
    else $error("irq zero wrong");
  a_ext_one: assert property (@(posedge clock) disable iff (rst) // [RQ2] [RQ15]
    (lowTake && irqPending[1:0] == 2'h2) |=> (vecOut.valid && vecOut.addr == 13'h0004))
    else $error("irq one wrong");
  a_prio_low: assert property (@(posedge clock) disable iff (rst) // [RQ15]
    (state_q == IVAM_ST_RUN && irqAck && irqPending[4:0] == 5'h10) |=> (vecOut.index == 5'h04))
    else $error("lowest request not served first");

  // ----------------------------------------
  // table slots, literal addresses kept apart from the formula
  // ----------------------------------------
  a_pin_zero: assert property (@(posedge clock) disable iff (rst) // [RQ3]
    (lowTake && irqPending == 25'h0000004) |=> (vecOut.valid && vecOut.addr == 13'h0006))
    else $error("pin change zero vector wrong");
  a_pin_one: assert property (@(posedge clock) disable iff (rst) // [RQ3]
    (lowTake && irqPending == 25'h0000008) |=> (vecOut.valid && vecOut.addr == 13'h0008))
    else $error("pin change one vector wrong");
  a_pin_two: assert property (@(posedge clock) disable iff (rst) // [RQ3]
    (lowTake && irqPending == 25'h0000010) |=> (vecOut.valid && vecOut.addr == 13'h000a))
    else $error("pin change two vector wrong");
  a_watchdog_slot: assert property (@(posedge clock) disable iff (rst) // [RQ3]
    (lowTake && irqPending == 25'h0000020) |=> (vecOut.valid && vecOut.addr == 13'h000c))
    else $error("watchdog vector wrong");
  a_two_match_a: assert property (@(posedge clock) disable iff (rst) // [RQ4]
    (lowTake && irqPending == 25'h0000040) |=> (vecOut.valid && vecOut.addr == 13'h000e))
    else $error("timer two match a vector wrong");
  a_two_match_b: assert property (@(posedge clock) disable iff (rst) // [RQ4]
    (lowTake && irqPending == 25'h0000080) |=> (vecOut.valid && vecOut.addr == 13'h0010))
    else $error("timer two match b vector wrong");
  a_two_wrap: assert property (@(posedge clock) disable iff (rst) // [RQ4]
    (lowTake && irqPending == 25'h0000100) |=> (vecOut.valid && vecOut.addr == 13'h0012))
    else $error("timer two overflow vector wrong");
  a_one_capture: assert property (@(posedge clock) disable iff (rst) // [RQ5]
    (lowTake && irqPending == 25'h0000200) |=> (vecOut.valid && vecOut.addr == 13'h0014))
    else $error("timer one capture vector wrong");
  a_one_match_a: assert property (@(posedge clock) disable iff (rst) // [RQ5]
    (lowTake && irqPending == 25'h0000400) |=> (vecOut.valid && vecOut.addr == 13'h0016))
    else $error("timer one match a vector wrong");
  a_one_match_b: assert property (@(posedge clock) disable iff (rst) // [RQ5]
    (lowTake && irqPending == 25'h0000800) |=> (vecOut.valid && vecOut.addr == 13'h0018))
    else $error("timer one match b vector wrong");
  a_one_wrap: assert property (@(posedge clock) disable iff (rst) // [RQ5]
    (lowTake && irqPending == 25'h0001000) |=> (vecOut.valid && vecOut.addr == 13'h001a))
    else $error("timer one overflow vector wrong");
  a_zero_match_a: assert property (@(posedge clock) disable iff (rst) // [RQ6]
    (lowTake && irqPending == 25'h0002000) |=> (vecOut.valid && vecOut.addr == 13'h001c))
    else $error("timer zero match a vector wrong");
  a_zero_match_b: assert property (@(posedge clock) disable iff (rst) // [RQ6]
    (lowTake && irqPending == 25'h0004000) |=> (vecOut.valid && vecOut.addr == 13'h001e))
    else $error("timer zero match b vector wrong");
  a_zero_wrap: assert property (@(posedge clock) disable iff (rst) // [RQ6]
    (lowTake && irqPending == 25'h0008000) |=> (vecOut.valid && vecOut.addr == 13'h0020))
    else $error("timer zero overflow vector wrong");
  a_spi_done: assert property (@(posedge clock) disable iff (rst) // [RQ7]
    (lowTake && irqPending == 25'h0010000) |=> (vecOut.valid && vecOut.addr == 13'h0022))
    else $error("serial peripheral vector wrong");
  a_rx_done: assert property (@(posedge clock) disable iff (rst) // [RQ8]
    (lowTake && irqPending == 25'h0020000) |=> (vecOut.valid && vecOut.addr == 13'h0024))
    else $error("receive complete vector wrong");
  a_tx_empty: assert property (@(posedge clock) disable iff (rst) // [RQ8]
    (lowTake && irqPending == 25'h0040000) |=> (vecOut.valid && vecOut.addr == 13'h0026))
    else $error("transmit buffer empty vector wrong");
  a_tx_done: assert property (@(posedge clock) disable iff (rst) // [RQ8]
    (lowTake && irqPending == 25'h0080000) |=> (vecOut.valid && vecOut.addr == 13'h0028))
    else $error("transmit complete vector wrong");
  a_conv_done: assert property (@(posedge clock) disable iff (rst) // [RQ9]
    (lowTake && irqPending == 25'h0100000) |=> (vecOut.valid && vecOut.addr == 13'h002a))
    else $error("conversion complete vector wrong");
  a_eeprom_ready: assert property (@(posedge clock) disable iff (rst) // [RQ9]
    (lowTake && irqPending == 25'h0200000) |=> (vecOut.valid && vecOut.addr == 13'h002c))
    else $error("eeprom ready vector wrong");
  a_comparator_slot: assert property (@(posedge clock) disable iff (rst) // [RQ9]
    (lowTake && irqPending == 25'h0400000) |=> (vecOut.valid && vecOut.addr == 13'h002e))
    else $error("comparator vector wrong");
  a_two_wire: assert property (@(posedge clock) disable iff (rst) // [RQ9]
    (lowTake && irqPending == 25'h0800000) |=> (vecOut.valid && vecOut.addr == 13'h0030))
    else $error("two wire vector wrong");
  a_last_slot: assert property (@(posedge clock) disable iff (rst) // [RQ9]
    (lowTake && irqPending == 25'h1000000) |=> (vecOut.valid && vecOut.addr == 13'h0032))
    else $error("last vector wrong");

  // ----------------------------------------
  // relocation and spacing
  // ----------------------------------------
  a_boot_keep_low: assert property (@(posedge clock) disable iff (rst) // [RQ10]
    (lowTake && !boot_reset_fuse && irqPending[0]) |=> (vecOut.addr == 13'h0002))
    else $error("fuse moved the vectors");
  a_boot_vectors: assert property (@(posedge clock) disable iff (rst) // [RQ11] [RQ13]
    (highTake && irqPending[0]) |=> (vecOut.valid && vecOut.addr == 13'h0c02))
    else $error("relocated vector wrong");
  a_boot_last: assert property (@(posedge clock) disable iff (rst) // [RQ13]
    (highTake && irqPending == 25'h1000000) |=> (vecOut.valid && vecOut.addr == 13'h0c32))
    else $error("relocated last vector wrong");
  a_slot_form: assert property (@(posedge clock) disable iff (rst) // [RQ16]
    (vecOut.valid && !vecOut.isReset) |->
    (vecOut.addr[5:0] == 6'((vecOut.index + 6'h01) * 2))) else $error("slot spacing");
  a_no_idle: assert property (@(posedge clock) disable iff (rst) // [RQ15]
    (state_q == IVAM_ST_RUN && !(irqAck && |irqPending)) |=> !vecOut.valid)
    else $error("spurious vector");
endmodule // ivam_vector_map

// ===== sim/ivam_core_model.sv
// Purpose: stand-in for the core fetch side
// Assumes: vector arrives one cycle after the ack edge
// Notes: ack is a plain pass of the bench request
`timescale 1ns/100ps
module ivam_core_model import ivam_pkg::*; (
  input wire logic clock,
  input wire logic want,
  input ivam_vec_t vecIn,
  output logic irqAck,
  output ivam_addr_t taken
);
  assign irqAck = want;
  // keeps the last fetched entry, as a jump target
  always_ff @(posedge clock) begin
    if (vecIn.valid) taken <= vecIn.addr;
  end
endmodule // ivam_core_model

// ===== sim/tb_ivam_vector_map.sv
// Purpose: self-checking bench for the vector map
// Assumes: one request per two cycles
// Notes: expectations from base plus twice (irq index plus one)
`timescale 1ns/100ps
module tb_ivam_vector_map import ivam_pkg::*;;
  logic clock, rst, fuse, sel, want, irqAck;
  logic [24:0] pend;
  ivam_vec_t vecOut;
  ivam_addr_t taken;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  ivam_vector_map ivam_vector_map_i (.clock(clock), .rst(rst), .boot_reset_fuse(fuse),
    .vector_select_bit(sel), .irqPending(pend), .irqAck(irqAck), .vecOut(vecOut));
  ivam_core_model ivam_core_model_i (.clock(clock), .want(want), .vecIn(vecOut),
    .irqAck(irqAck), .taken(taken));
  // ----------
  // tasks
  // ----------
  task chk(string what, logic [19:0] seen, logic [19:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task finish_test();
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task do_reset(logic f);
    @(posedge clock);
    fuse <= f;
    rst <= 1'h1;
    repeat (3) @(posedge clock);
    rst <= 1'h0;
    @(posedge clock);
    #1;
    chk("reset", {vecOut.valid, vecOut.isReset, vecOut.addr}, {2'h3, f ? 13'h0 : 13'h0c00});
  endtask
  task irq(logic [24:0] p, logic [4:0] i);
    @(posedge clock);
    pend <= p;
    want <= 1'h1;
    @(posedge clock);
    want <= 1'h0;
    pend <= '0;
    #1;
    chk("vector", vecOut, {2'h2, i, (sel ? 13'h0c00 : 13'h0) + 13'(2 * i + 2)});
  endtask
  task map(logic s);
    @(posedge clock);
    sel <= s;
    for (int k = 0; k < 25; k++) irq(25'h1 << k, 5'(k));
  endtask
  task refuse();
    @(posedge clock);
    want <= 1'h1;
    @(posedge clock);
    want <= 1'h0;
    #1;
    chk("refused", 20'(vecOut.valid), 20'h0);
    chk("held", 20'(vecOut.addr), 20'h0c0a);
    chk("taken", 20'(taken), 20'h0c0a);
  endtask
  // ----------
  // run
  // ----------
  initial begin
    clock = 0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 1000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    rst = 1'h1;
    fuse = 1'h1;
    sel = 1'h0;
    want = 1'h0;
    pend = '0;
    do_reset(1'h1);
    map(1'h0);
    map(1'h1);
    do_reset(1'h1);
    do_reset(1'h0);
    map(1'h0);
    map(1'h1);
    irq(25'h1000210, 5'h4);
    refuse();
    finish_test();
  end
endmodule // tb_ivam_vector_map
